// ### core/dcc_top.sv
// Detector call conditioner: zones, per-output timing and AXI4-Lite registers
// ==========================================================
// Contract
// RQ1: each output has its own timing mode, delay and extend setting.
// RQ2: full-time delay timer runs on detection regardless of phase green.
// RQ3: normal delay skips delay timing while green, unless option disables this.
// RQ4: extend mode holds the call for extend time after vehicle leaves.
// RQ5: delay/extend mode accepts a call only after the delay expires.
// RQ6: delay/extend call holds until zone empty and extend fully elapsed.
// RQ7: delay/extend re-entry during extend keeps call and restarts extend.
// RQ8: after extend expiry the delay must expire again before a new call.
// RQ9: each zone takes exactly one of four detection functions.
// RQ10: at least eight independent detection zones per camera.
// RQ11: at least eight separate call outputs per camera.
// RQ12: zones may overlap; each is evaluated and routed independently.
// RQ13: call asserted within 112 ms of vehicle arrival.
// RQ14: zone and output settings can be rewritten at any time.
// RQ15: camera or emulator failure forces calls on all outputs.
// RQ16: pulse zones emit one fixed configurable pulse per entry.
// RQ17: directional zones respond only to motion in their set direction.
// RQ18: timers count a shared free-running tick and clear on reset.
`timescale 1ns/10ps
module dcc_top import dcc_pkg::*; #(
  parameter int NZ          = NUM_ZONES,
  parameter int NOUT        = NUM_OUTS,
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic [2:0]      s_axi_awprot,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic [2:0]      s_axi_arprot,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [NZ-1:0]   zone_occ,
  input  wire logic [NZ-1:0]   zone_motion,
  input  wire logic [NOUT-1:0] phase_green,
  input  wire logic            cam_fail,
  output logic [NOUT-1:0]      det_call
);
  typedef struct packed {
    logic [1:0]                ctrl;
    logic [NOUT-1:0][23:0]     ocfg;
    logic [NZ-1:0][15:0]       zcfg;
    dcc_tstate_t [NOUT-1:0]    st;
    logic [NOUT-1:0][TW-1:0]   cnt;
    logic [NOUT-1:0]           call;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [1:0]                rresp;
    logic [31:0]               rdata;
  } dcc_top_st_t;

  dcc_top_st_t       s_q, s_d;
  logic              tick;
  logic [NZ-1:0]     zone_act;
  logic [NOUT-1:0]   det;
  dcc_omode_t        mode    [NOUT];
  logic [TW-1:0]     eff_dly [NOUT];
  logic [TW-1:0]     eff_ext [NOUT];
  logic              fail;
  logic              aw_take;
  logic              ar_take;
  logic              wr_hit;
  logic [23:0]       wdat_lo;

  // ==========================================================
  // decode helpers
  function automatic logic f_hit(input logic [7:0] a, input logic [7:0] base, input int n);
    return (a[7:5] == base[7:5]) && (int'(a[4:2]) < n);
  endfunction

  function automatic logic f_mapped(input logic [7:0] a);
    return (a == CTRL_OFS) || (a == STATUS_OFS) || f_hit(a, OCFG_BASE, NOUT) || f_hit(a, ZCFG_BASE, NZ);
  endfunction

  function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  // ==========================================================
  // time base and zones
  dcc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  for (genvar z = 0; z < NZ; z++) begin : g_zone // [RQ10]
    dcc_zone #(
      .W (TW)
    ) u_zone (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick),
      .occ     (zone_occ[z]),
      .motion  (zone_motion[z]),
      .fn      (s_q.zcfg[z][ZCFG_FN_LSB +: 2]), // [RQ9]
      .dir     (s_q.zcfg[z][ZCFG_DIR_BIT]),
      .plen    (s_q.zcfg[z][ZCFG_PLEN_LSB +: TW]),
      .active  (zone_act[z])
    );
  end

  // overlapping zones each feed their own chosen output
  always_comb begin
    det = '0;
    for (int z = 0; z < NZ; z++) begin
      for (int o = 0; o < NOUT; o++) begin
        if (int'(s_q.zcfg[z][ZCFG_OUT_LSB +: 3]) == o) det[o] = det[o] | zone_act[z]; // [RQ12]
      end
    end
  end

  // ==========================================================
  // per-output timing parameters
  for (genvar i = 0; i < NOUT; i++) begin : g_cfg // [RQ11]
    assign mode[i] = dcc_omode_t'(s_q.ocfg[i][OCFG_MODE_LSB +: 2]); // [RQ1]
    // green bypasses delay in normal mode; the option keeps full-time behaviour
    assign eff_dly[i] = ((mode[i] == OM_EXTEND) || ((mode[i] == OM_NORMAL_DELAY) && phase_green[i] // [RQ3]
                        && !s_q.ctrl[CTRL_NOINH_BIT])) ? '0 : s_q.ocfg[i][OCFG_DLY_LSB +: TW]; // [RQ2]
    assign eff_ext[i] = ((mode[i] == OM_EXTEND) || (mode[i] == OM_DELAY_EXTEND)) // [RQ4]
                        ? s_q.ocfg[i][OCFG_EXT_LSB +: TW] : '0;
  end

  assign fail    = cam_fail || s_q.ctrl[CTRL_FORCE_BIT];
  assign aw_take = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign ar_take = s_axi_arvalid && !s_q.rvalid;
  assign wr_hit  = f_mapped(s_axi_awaddr);
  assign wdat_lo = s_axi_wdata[23:0];

  // ==========================================================
  // next state
  always_comb begin
    logic [2:0] idx;
    idx = '0;
    s_d = s_q;

    // write channel: address and data are taken in the same cycle
    if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
    if (aw_take) begin
      idx = s_axi_awaddr[4:2];
      s_d.bvalid = 1'b1;
      s_d.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_awaddr == CTRL_OFS) begin
        s_d.ctrl = 2'(f_merge({30'h00000000, s_q.ctrl}, s_axi_wdata, s_axi_wstrb));
      end else if (f_hit(s_axi_awaddr, OCFG_BASE, NOUT)) begin
        s_d.ocfg[idx] = 24'(f_merge({8'h00, s_q.ocfg[idx]}, s_axi_wdata, s_axi_wstrb)); // [RQ14]
      end else if (f_hit(s_axi_awaddr, ZCFG_BASE, NZ)) begin
        s_d.zcfg[idx] = 16'(f_merge({16'h0000, s_q.zcfg[idx]}, s_axi_wdata, s_axi_wstrb)); // [RQ14]
      end
    end

    // read channel
    if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = '0;
      s_d.rresp  = f_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == CTRL_OFS) begin
        s_d.rdata[1:0] = s_q.ctrl;
      end else if (s_axi_araddr == STATUS_OFS) begin
        s_d.rdata[NOUT-1:0] = s_q.call;
        s_d.rdata[STAT_ZONE_LSB +: NZ] = zone_act;
      end else if (f_hit(s_axi_araddr, OCFG_BASE, NOUT)) begin
        s_d.rdata[23:0] = s_q.ocfg[s_axi_araddr[4:2]];
      end else if (f_hit(s_axi_araddr, ZCFG_BASE, NZ)) begin
        s_d.rdata[15:0] = s_q.zcfg[s_axi_araddr[4:2]];
      end
    end

    // call timers, one per output
    for (int i = 0; i < NOUT; i++) begin
      unique case (s_q.st[i])
        TS_IDLE: begin
          if (!det[i]) begin
            s_d.cnt[i] = '0;
          end else if (s_q.cnt[i] >= eff_dly[i]) begin // [RQ5]
            s_d.st[i]  = TS_CALL;
            s_d.cnt[i] = '0;
          end else if (tick) begin
            s_d.cnt[i] = s_q.cnt[i] + 1'b1; // [RQ2] [RQ18]
          end
        end
        TS_CALL: begin
          s_d.cnt[i] = '0;
          if (!det[i]) s_d.st[i] = (eff_ext[i] == '0) ? TS_IDLE : TS_EXT; // [RQ4] [RQ6]
        end
        TS_EXT: begin
          if (det[i]) begin
            s_d.st[i]  = TS_CALL; // [RQ7]
            s_d.cnt[i] = '0;
          end else if (s_q.cnt[i] >= eff_ext[i]) begin
            s_d.st[i]  = TS_IDLE; // [RQ8]
            s_d.cnt[i] = '0;
          end else if (tick) begin
            s_d.cnt[i] = s_q.cnt[i] + 1'b1; // [RQ18]
          end
        end
        default: begin
          s_d.st[i]  = TS_IDLE;
          s_d.cnt[i] = '0;
        end
      endcase
      // a failed camera must never leave an approach uncalled
      s_d.call[i] = fail || (s_d.st[i] != TS_IDLE); // [RQ15] [RQ13]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q      <= '0; // [RQ18]
      s_q.ctrl <= CTRL_RST;
      for (int i = 0; i < NOUT; i++) begin
        s_q.ocfg[i] <= OCFG_RST;
      end
      for (int z = 0; z < NZ; z++) begin
        s_q.zcfg[z] <= ZCFG_RST | 16'(z << ZCFG_OUT_LSB);
      end
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = aw_take;
  assign s_axi_wready  = aw_take;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;
  assign det_call      = s_q.call;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  cfg_write_a: assert property (aw_take && s_axi_awaddr == OCFG_BASE && s_axi_wstrb == 4'hF // [RQ14]
    |=> s_q.ocfg[0] == $past(wdat_lo))
    else $error("output setting not updated by write");
  bad_addr_a: assert property (aw_take && !wr_hit |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  for (genvar i = 0; i < NOUT; i++) begin : g_chk
    sequence s_in_ext;
      s_q.st[i] == TS_EXT && mode[i] == OM_DELAY_EXTEND;
    endsequence
    sequence s_back_call;
      s_q.st[i] == TS_CALL && s_q.cnt[i] == '0 && det_call[i];
    endsequence

    full_dly_a: assert property (mode[i] == OM_FULL_DELAY && phase_green[i] && s_q.st[i] == TS_IDLE // [RQ2]
      && det[i] && s_q.cnt[i] < s_q.ocfg[i][OCFG_DLY_LSB +: TW] && !tick |=> s_q.st[i] == TS_IDLE)
      else $error("full-time delay bypassed on green");
    green_inh_a: assert property (mode[i] == OM_NORMAL_DELAY && phase_green[i] && !s_q.ctrl[CTRL_NOINH_BIT] // [RQ3]
      && s_q.st[i] == TS_IDLE && det[i] |=> s_q.st[i] == TS_CALL && det_call[i])
      else $error("green did not bypass normal delay");
    ext_hold_a: assert property (mode[i] == OM_EXTEND && s_q.st[i] == TS_CALL && !det[i] // [RQ4]
      && eff_ext[i] != '0 |=> s_q.st[i] == TS_EXT && det_call[i])
      else $error("extend did not hold the call");
    dx_gate_a: assert property (mode[i] == OM_DELAY_EXTEND && s_q.st[i] == TS_IDLE && det[i] // [RQ5]
      && eff_dly[i] != '0 && s_q.cnt[i] == '0 && !tick |=> s_q.st[i] == TS_IDLE)
      else $error("call accepted before delay expired");
    dx_hold_a: assert property (mode[i] == OM_DELAY_EXTEND && s_q.st[i] == TS_CALL && det[i] // [RQ6]
      |=> s_q.st[i] == TS_CALL ##0 det_call[i])
      else $error("call dropped while zone occupied");
    dx_reentry_a: assert property (s_in_ext ##0 det[i] |=> s_back_call) // [RQ7]
      else $error("re-entry did not restart extend");
    dx_rearm_a: assert property (s_in_ext ##0 (!det[i] && s_q.cnt[i] >= eff_ext[i]) // [RQ8]
      |=> s_q.st[i] == TS_IDLE && s_q.cnt[i] == '0)
      else $error("delay not re-armed after extend");
    fast_call_a: assert property (s_q.st[i] == TS_IDLE && det[i] && eff_dly[i] == '0 |=> det_call[i]) // [RQ13]
      else $error("call late with no delay");
    fail_call_a: assert property (fail |=> det_call[i]) // [RQ15]
      else $error("failure did not force call");
  end
endmodule // dcc_top

// ### pkg/dcc_pkg.sv
// Shared constants and types for the detector call conditioner
package dcc_pkg;
  localparam int NUM_ZONES = 8;
  localparam int NUM_OUTS  = 8;
  localparam int TW        = 8;
  localparam int CLK_HZ    = 40_000_000;
  localparam int TICK_US   = 100_000;
  localparam int TICK_CYC  = (CLK_HZ / 1_000_000) * TICK_US;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] OCFG_BASE  = 8'h20;
  localparam logic [7:0] ZCFG_BASE  = 8'h40;

  localparam int CTRL_NOINH_BIT = 0;
  localparam int CTRL_FORCE_BIT = 1;
  localparam int OCFG_MODE_LSB  = 0;
  localparam int OCFG_DLY_LSB   = 8;
  localparam int OCFG_EXT_LSB   = 16;
  localparam int ZCFG_FN_LSB    = 0;
  localparam int ZCFG_DIR_BIT   = 2;
  localparam int ZCFG_OUT_LSB   = 4;
  localparam int ZCFG_PLEN_LSB  = 8;
  localparam int STAT_ZONE_LSB  = 8;

  localparam logic [1:0]  CTRL_RST = 2'h0;
  localparam logic [23:0] OCFG_RST = 24'h000000;
  localparam logic [15:0] ZCFG_RST = 16'h0100;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // modes and states
  typedef enum logic [1:0] {
    OM_FULL_DELAY, OM_NORMAL_DELAY, OM_EXTEND, OM_DELAY_EXTEND
  } dcc_omode_t;

  typedef enum logic [1:0] {
    ZF_PRESENCE, ZF_DIR_PRESENCE, ZF_PULSE, ZF_DIR_PULSE
  } dcc_zfn_t;

  typedef enum logic [1:0] {TS_IDLE, TS_CALL, TS_EXT} dcc_tstate_t;
endpackage

// ### core/dcc_tick.sv
// Free-running time base for the call timers
`timescale 1ns/10ps
module dcc_tick import dcc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } dcc_tick_st_t;

  dcc_tick_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == CW'(TICK_CYCLES - 1)) begin // [RQ18]
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0; // [RQ18]
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  tick_phase_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ18]
    s_q.tick |-> s_q.cnt == '0)
    else $error("tick not aligned to counter wrap");
endmodule // dcc_tick

// ### core/dcc_zone.sv
// One detection zone: presence, directional and pulse functions
`timescale 1ns/10ps
module dcc_zone import dcc_pkg::*; #(
  parameter int W = TW
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         tick,
  input  wire logic         occ,
  input  wire logic         motion,
  input  wire logic [1:0]   fn,
  input  wire logic         dir,
  input  wire logic [W-1:0] plen,
  output logic              active
);
  typedef struct packed {
    logic         prev;
    logic [W-1:0] cnt;
    logic         act;
  } dcc_zone_st_t;

  dcc_zone_st_t s_q, s_d;
  dcc_zfn_t     zfn;
  logic         is_dir;
  logic         is_pulse;
  logic         qual;

  assign zfn      = dcc_zfn_t'(fn); // [RQ9]
  assign is_dir   = (zfn == ZF_DIR_PRESENCE) || (zfn == ZF_DIR_PULSE);
  assign is_pulse = (zfn == ZF_PULSE) || (zfn == ZF_DIR_PULSE);
  // motion in the other direction is ignored
  assign qual     = occ && (!is_dir || (motion == dir)); // [RQ17]

  always_comb begin
    s_d = s_q;
    s_d.prev = qual;
    if (!is_pulse) begin
      s_d.act = qual;
      s_d.cnt = '0;
    end else if (qual && !s_q.prev) begin // [RQ16]
      s_d.act = 1'b1;
      s_d.cnt = '0;
    end else if (s_q.act && tick) begin
      // zero length behaves as one tick
      if (s_q.cnt + 1'b1 >= plen) begin // [RQ16]
        s_d.act = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.act;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  pulse_start_a: assert property (is_pulse && qual && !s_q.prev |=> active) // [RQ16]
    else $error("pulse not started on entry");
  pulse_end_a: assert property (is_pulse && s_q.act && tick && !(qual && !s_q.prev) // [RQ16]
    && (s_q.cnt + 1'b1 >= plen) |=> !active)
    else $error("pulse outlived its length");
  dir_block_a: assert property (zfn == ZF_DIR_PRESENCE && motion != dir |=> !active) // [RQ17]
    else $error("wrong-way motion raised a call");
endmodule // dcc_zone

// ### bench/dcc_ctrl_model.sv
// Controller-side partner model: drives phase greens and counts call onsets on output 0
`timescale 1ns/10ps
module dcc_ctrl_model import dcc_pkg::*; (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [NUM_OUTS-1:0] det_call,
  input  wire logic [NUM_OUTS-1:0] green_req,
  output logic [NUM_OUTS-1:0]      phase_green,
  output logic [15:0]              call_onsets
);
  logic [NUM_OUTS-1:0] call_prev_q;

  // greens move only on a clock edge, like real controller outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_green <= '0;
      call_prev_q <= '0;
      call_onsets <= '0;
    end else begin
      phase_green <= green_req;
      call_prev_q <= det_call;
      if (det_call[0] && !call_prev_q[0]) begin
        call_onsets <= call_onsets + 16'h0001;
      end
    end
  end
endmodule // dcc_ctrl_model

// ### bench/detector_call_conditioner_tb_top.sv
// Self-checking testbench for the detector call conditioner
`timescale 1ns/10ps
module detector_call_conditioner_tb_top import dcc_pkg::*; ;
  localparam int TC = 4;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cam_fail = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] zone_occ = 8'h00, zone_motion = 8'h00, green_req = 8'h00, phase_green, det_call;
  logic [15:0] call_onsets, ons;
  int err_count = 0, n_compared = 0, cyc = 0;

  always #12.5 aclk = ~aclk;

  dcc_top #(.TICK_CYCLES(TC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .zone_occ(zone_occ), .zone_motion(zone_motion),
    .phase_green(phase_green), .cam_fail(cam_fail), .det_call(det_call));

  dcc_ctrl_model ctrl (.aclk(aclk), .aresetn(aresetn), .det_call(det_call),
    .green_req(green_req), .phase_green(phase_green), .call_onsets(call_onsets));

  // ==========================================================
  // shared tasks
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ready is looked at mid-cycle, so the next rising edge is the take
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_awready !== 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic occ(input logic [7:0] o, input logic [7:0] m);
    @(posedge aclk);
    zone_occ <= o;
    zone_motion <= m;
  endtask

  // cycles counted from the edge that launched the input change
  task automatic wait_call(input int i, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (det_call[i] !== v && n < hi);
    n_compared++;
    if (det_call[i] !== v || n < lo) begin
      err_count++;
      $display("BAD det_call[%0d] expected %b in %0d..%0d, seen %b at %0d", i, v, lo, hi, det_call[i], n);
    end
  endtask

  task automatic hold_call(input int i, input logic v, input int n);
    repeat (n) begin
      @(negedge aclk);
      chk("det_call held", {31'h0, v}, {31'h0, det_call[i]});
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic s_regs();
    axi_rd(CTRL_OFS, rd, rr);
    chk("ctrl reset", 32'h0, rd);
    chk("ctrl resp", {30'h0, RESP_OKAY}, {30'h0, rr});
    axi_rd(8'h4C, rd, rr);
    chk("zcfg3 reset", 32'h00000130, rd);
    axi_wr(8'h28, 32'h00030201, RESP_OKAY);
    axi_rd(8'h28, rd, rr);
    chk("ocfg2 back", 32'h00030201, rd);
    // only byte lane 1 may change
    s_axi_wstrb <= 4'h2;
    axi_wr(8'h28, 32'hFFFFAAFF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(8'h28, rd, rr);
    chk("ocfg2 byte lane", 32'h0003AA01, rd);
    axi_wr(8'h10, 32'hFFFFFFFF, RESP_SLVERR);
    axi_rd(8'h10, rd, rr);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic s_delays();
    green_req <= 8'h01;
    axi_wr(8'h20, 32'h00000300, RESP_OKAY);
    occ(8'h01, 8'h00);
    wait_call(0, 1'b1, 2*TC+2, 3*TC+4);
    occ(8'h00, 8'h00);
    wait_call(0, 1'b0, 2, 4);
    axi_wr(8'h20, 32'h00000301, RESP_OKAY);
    occ(8'h01, 8'h00);
    wait_call(0, 1'b1, 2, 4);
    occ(8'h00, 8'h00);
    wait_call(0, 1'b0, 2, 4);
    axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
    occ(8'h01, 8'h00);
    wait_call(0, 1'b1, 2*TC+2, 3*TC+4);
    occ(8'h00, 8'h00);
    wait_call(0, 1'b0, 2, 4);
    axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
    green_req <= 8'h00;
    occ(8'h02, 8'h00);
    wait_call(1, 1'b1, 2, 4);
    occ(8'h00, 8'h00);
    wait_call(1, 1'b0, 2, 4);
  endtask

  task automatic s_extends();
    axi_wr(8'h20, 32'h00030002, RESP_OKAY);
    occ(8'h01, 8'h00);
    wait_call(0, 1'b1, 2, 4);
    occ(8'h00, 8'h00);
    wait_call(0, 1'b0, 2*TC+2, 3*TC+4);
    axi_wr(8'h20, 32'h00030203, RESP_OKAY);
    occ(8'h01, 8'h00);
    wait_call(0, 1'b1, TC+2, 2*TC+4);
    occ(8'h00, 8'h00);
    hold_call(0, 1'b1, TC);
    occ(8'h01, 8'h00);
    hold_call(0, 1'b1, 2);
    occ(8'h00, 8'h00);
    wait_call(0, 1'b0, 2*TC+2, 3*TC+4);
    occ(8'h01, 8'h00);
    wait_call(0, 1'b1, TC+2, 2*TC+4);
    occ(8'h00, 8'h00);
    wait_call(0, 1'b0, 2*TC+2, 3*TC+4);
    axi_wr(8'h20, 32'h0, RESP_OKAY);
  endtask

  task automatic s_zones();
    axi_wr(8'h40, 32'h00000302, RESP_OKAY);
    ons = call_onsets;
    occ(8'h01, 8'h00);
    wait_call(0, 1'b1, 2, 4);
    wait_call(0, 1'b0, 2*TC, 3*TC+2);
    hold_call(0, 1'b0, 2*TC);
    occ(8'h00, 8'h00);
    chk("pulse onsets", 32'h1, {16'h0, call_onsets - ons});
    axi_wr(8'h40, 32'h00000307, RESP_OKAY);
    occ(8'h01, 8'h00);
    hold_call(0, 1'b0, 6);
    occ(8'h00, 8'h00);
    occ(8'h01, 8'h01);
    wait_call(0, 1'b1, 2, 4);
    occ(8'h00, 8'h00);
    wait_call(0, 1'b0, 2, 3*TC+4);
    axi_wr(8'h40, 32'h00000105, RESP_OKAY);
    occ(8'h01, 8'h00);
    hold_call(0, 1'b0, 6);
    occ(8'h01, 8'h01);
    wait_call(0, 1'b1, 2, 4);
    occ(8'h01, 8'h00);
    wait_call(0, 1'b0, 2, 4);
    occ(8'h00, 8'h00);
    axi_wr(8'h40, 32'h00000100, RESP_OKAY);
    axi_wr(8'h44, 32'h00000100, RESP_OKAY);
    occ(8'h02, 8'h00);
    wait_call(0, 1'b1, 2, 4);
    chk("unrouted output", 32'h0, {31'h0, det_call[1]});
    occ(8'h00, 8'h00);
    wait_call(0, 1'b0, 2, 4);
  endtask

  task automatic s_fail();
    @(posedge aclk);
    cam_fail <= 1'b1;
    repeat (3) @(negedge aclk);
    chk("fail calls", 32'hFF, {24'h0, det_call});
    @(posedge aclk);
    cam_fail <= 1'b0;
    axi_wr(CTRL_OFS, 32'h2, RESP_OKAY);
    axi_rd(STATUS_OFS, rd, rr);
    chk("forced status", 32'hFF, rd & 32'h000000FF);
    axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
    repeat (3) @(negedge aclk);
    chk("calls released", 32'h0, {24'h0, det_call});
  endtask

  // ==========================================================
  // main sequence and hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    s_delays();
    s_extends();
    s_zones();
    s_fail();
    tally_and_finish();
  end
endmodule // detector_call_conditioner_tb_top
